// ==== paccum_pkg.sv ====
// Package: register map, field positions and constants for the pulse accumulator
package paccum_pkg;

  // ---------------------------------------------------------------
  // Register word addresses
  // ---------------------------------------------------------------
  localparam logic [1:0] ADDR_CONTROL = 2'h0;
  localparam logic [1:0] ADDR_FLAGS = 2'h1;
  localparam logic [1:0] ADDR_COUNT = 2'h2;
  localparam logic [1:0] ADDR_TIMER_CFG = 2'h3;

  // ---------------------------------------------------------------
  // Control fields
  // ---------------------------------------------------------------
  localparam int CTL_ENABLE_BIT = 6;
  localparam int CTL_MODE_BIT = 5;
  localparam int CTL_EDGE_BIT = 4;
  localparam int CTL_CLKSEL_HI = 3;
  localparam int CTL_CLKSEL_LO = 2;
  localparam int CTL_OVF_IRQ_EN_BIT = 1;
  localparam int CTL_IN_IRQ_EN_BIT = 0;
  localparam logic [7:0] CTL_WRITE_MASK = 8'h7f;

  // ---------------------------------------------------------------
  // Flag fields
  // ---------------------------------------------------------------
  localparam int FLG_OVF_BIT = 1;
  localparam int FLG_IN_BIT = 0;

  // ---------------------------------------------------------------
  // Timer configuration fields
  // ---------------------------------------------------------------
  localparam int CFG_TIMER_EN_BIT = 0;
  localparam int CFG_FAST_CLR_BIT = 1;

  // ---------------------------------------------------------------
  // Reset values and counts
  // ---------------------------------------------------------------
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [1:0] FLAGS_RESET = 2'h0;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [1:0] CFG_RESET = 2'h0;
  localparam int GATE_DIVIDE = 64;
  localparam logic [7:0] DIV256_LAST = 8'hff;
  localparam logic [15:0] DIV65536_LAST = 16'hffff;

  // ---------------------------------------------------------------
  // Clock source selections
  // ---------------------------------------------------------------
  localparam logic [1:0] CLKSEL_PRESCALER = 2'h0;
  localparam logic [1:0] CLKSEL_ACCUM = 2'h1;
  localparam logic [1:0] CLKSEL_DIV256 = 2'h2;
  localparam logic [1:0] CLKSEL_DIV65536 = 2'h3;

endpackage : paccum_pkg

// ==== paccum_ctrl.sv ====
// Pulse accumulator control, flags, counter and timer clock selection
module paccum_ctrl #(
  parameter int PRESCALE_DIVIDE = 1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic accum_input_pin,
  output logic timer_enable,
  output logic accum_clock,
  output logic counter_tick,
  output logic accum_irq
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] accum_control;
    logic accum_overflow_flag;
    logic accum_input_flag;
    logic [15:0] accum_count;
    logic timer_enable;
    logic fast_flag_clear_all;
    logic pin_sync1;
    logic pin_sync2;
    logic pin_prev;
    logic [7:0] prescale_cnt;
    logic [5:0] div64_cnt;
    logic ack;
    logic [31:0] rdata;
    logic accum_clock;
    logic counter_tick;
  } paccum_state_t;

  paccum_state_t cur;
  paccum_state_t next_cur;

  logic accum_enable;
  logic accum_mode_select;
  logic accum_edge_select;
  logic [1:0] clk_select;
  logic rise;
  logic fall;
  logic prescale_tick;
  logic div64_tick;
  logic gate_open;
  logic event_edge;
  logic trailing_edge;
  logic accum_inc;
  logic wr_ctl;
  logic wr_flg;
  logic wr_cnt;
  logic wr_cfg;
  logic cnt_access;
  logic div256_tick;
  logic div65536_tick;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  assign accum_enable = cur.accum_control[paccum_pkg::CTL_ENABLE_BIT];
  assign accum_mode_select = cur.accum_control[paccum_pkg::CTL_MODE_BIT];
  assign accum_edge_select = cur.accum_control[paccum_pkg::CTL_EDGE_BIT];
  assign clk_select = cur.accum_control[paccum_pkg::CTL_CLKSEL_HI:paccum_pkg::CTL_CLKSEL_LO];

  // Edges seen only after the second sync stage
  assign rise = cur.pin_sync2 & ~cur.pin_prev;
  assign fall = ~cur.pin_sync2 & cur.pin_prev;

  // Prescaler stand-in; silent while the timer is off
  assign prescale_tick = cur.timer_enable
    && (cur.prescale_cnt == 8'(PRESCALE_DIVIDE - 1));
  assign div64_tick = prescale_tick
    && (cur.div64_cnt == 6'(paccum_pkg::GATE_DIVIDE - 1));

  // Gate level: low input when edge bit is 1, high when 0
  assign gate_open = accum_edge_select ? ~cur.pin_sync2 : cur.pin_sync2;
  // Event edge choice
  assign event_edge = accum_edge_select ? rise : fall;
  // Trailing edge of the gate
  assign trailing_edge = accum_edge_select ? rise : fall;

  // Mode choice; event mode ignores timer enable
  assign accum_inc = accum_enable
    && (accum_mode_select ? (gate_open && div64_tick) : event_edge);

  // Byte lane 0 carries control, flags and timer config; count uses lanes 0 and 1
  assign wr_ctl = avs_write && avs_byteenable[0] && avs_address == paccum_pkg::ADDR_CONTROL;
  assign wr_flg = avs_write && avs_byteenable[0] && avs_address == paccum_pkg::ADDR_FLAGS;
  assign wr_cfg = avs_write && avs_byteenable[0] && avs_address == paccum_pkg::ADDR_TIMER_CFG;
  assign wr_cnt = avs_write && avs_address == paccum_pkg::ADDR_COUNT;
  // One strobe per access, on the wait cycle before the acknowledge
  assign cnt_access = ~cur.ack && (avs_read || avs_write)
    && avs_address == paccum_pkg::ADDR_COUNT;

  // Dividers follow the count itself, so a count write realigns them
  assign div256_tick = cur.accum_count[7:0] == paccum_pkg::DIV256_LAST;
  assign div65536_tick = cur.accum_count == paccum_pkg::DIV65536_LAST;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    next_cur = cur;
    next_cur.ack = (avs_read || avs_write) && ~cur.ack;
    next_cur.pin_sync1 = accum_input_pin;
    next_cur.pin_sync2 = cur.pin_sync1;
    next_cur.pin_prev = cur.pin_sync2;

    if (cur.timer_enable)
    begin
      next_cur.prescale_cnt = prescale_tick ? 8'h00 : cur.prescale_cnt + 8'h01;
      if (prescale_tick)
      begin
        next_cur.div64_cnt = cur.div64_cnt + 6'h01;
      end
    end

    // Accumulator clock pulses follow each count step
    next_cur.accum_clock = accum_inc;

    // Counter clock chosen from the field while enabled; prescaler while the accumulator is off
    if (!accum_enable)
    begin
      next_cur.counter_tick = prescale_tick;
    end
    else
    begin
      case (clk_select)
        paccum_pkg::CLKSEL_PRESCALER: next_cur.counter_tick = prescale_tick;
        paccum_pkg::CLKSEL_ACCUM: next_cur.counter_tick = accum_inc;
        paccum_pkg::CLKSEL_DIV256: next_cur.counter_tick = accum_inc && div256_tick;
        paccum_pkg::CLKSEL_DIV65536: next_cur.counter_tick = accum_inc && div65536_tick;
        default: next_cur.counter_tick = prescale_tick;
      endcase
    end

    // Count steps on each accumulator increment; a same-cycle count write wins
    if (accum_inc)
    begin
      next_cur.accum_count = cur.accum_count + 16'h0001;
    end
    if (wr_cnt && ~cur.ack)
    begin
      if (avs_byteenable[0])
      begin
        next_cur.accum_count[7:0] = avs_writedata[7:0];
      end
      if (avs_byteenable[1])
      begin
        next_cur.accum_count[15:8] = avs_writedata[15:8];
      end
    end

    if (wr_ctl && ~cur.ack)
    begin
      next_cur.accum_control = avs_writedata[7:0] & paccum_pkg::CTL_WRITE_MASK;
    end
    if (wr_cfg && ~cur.ack)
    begin
      next_cur.timer_enable = avs_writedata[paccum_pkg::CFG_TIMER_EN_BIT];
      next_cur.fast_flag_clear_all = avs_writedata[paccum_pkg::CFG_FAST_CLR_BIT];
    end

    // Clears first, so a same-cycle set wins
    if (wr_flg && ~cur.ack)
    begin
      if (avs_writedata[paccum_pkg::FLG_OVF_BIT])
      begin
        next_cur.accum_overflow_flag = 1'b0;
      end
      if (avs_writedata[paccum_pkg::FLG_IN_BIT])
      begin
        next_cur.accum_input_flag = 1'b0;
      end
    end
    if (cnt_access && cur.fast_flag_clear_all)
    begin
      next_cur.accum_overflow_flag = 1'b0;
      next_cur.accum_input_flag = 1'b0;
    end
    if (accum_inc && cur.accum_count == paccum_pkg::COUNT_MAX)
    begin
      next_cur.accum_overflow_flag = 1'b1;
    end
    if (accum_enable && (accum_mode_select ? trailing_edge : event_edge))
    begin
      next_cur.accum_input_flag = 1'b1;
    end

    // Read data captured on the wait cycle, presented on the acknowledging cycle
    next_cur.rdata = 32'h00000000;
    if (avs_read && ~cur.ack)
    begin
      case (avs_address)
        paccum_pkg::ADDR_CONTROL: next_cur.rdata = {24'h000000, cur.accum_control};
        paccum_pkg::ADDR_FLAGS: next_cur.rdata = {30'h00000000,
          cur.accum_overflow_flag, cur.accum_input_flag};
        paccum_pkg::ADDR_COUNT: next_cur.rdata = {16'h0000, cur.accum_count};
        paccum_pkg::ADDR_TIMER_CFG: next_cur.rdata = {30'h00000000,
          cur.fast_flag_clear_all, cur.timer_enable};
        default: next_cur.rdata = 32'h00000000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      // Reset clears all state; control and count load their reset constants
      cur <= '0;
      cur.accum_control <= paccum_pkg::CONTROL_RESET;
      cur.accum_count <= paccum_pkg::COUNT_RESET;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // One wait cycle keeps read data registered
  assign avs_waitrequest = (avs_read || avs_write) && ~cur.ack;
  assign avs_readdata = cur.rdata;
  assign timer_enable = cur.timer_enable;
  assign accum_clock = cur.accum_clock;
  assign counter_tick = cur.counter_tick;
  assign accum_irq = (cur.accum_overflow_flag
    && cur.accum_control[paccum_pkg::CTL_OVF_IRQ_EN_BIT])
    || (cur.accum_input_flag
    && cur.accum_control[paccum_pkg::CTL_IN_IRQ_EN_BIT]);

endmodule : paccum_ctrl

// ==== paccum_ctrl_checker.sv ====
// Port-level checker for the pulse accumulator control block
module paccum_ctrl_checker #(
  parameter int PRESCALE_DIVIDE = 1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic accum_input_pin,
  input wire logic timer_enable,
  input wire logic accum_clock,
  input wire logic accum_irq
);
  // ------------------------------
  // Shadow state
  // ------------------------------
  logic [7:0] ctl_sh;
  logic [6:0] hist;
  logic [3:0] stl;
  logic [3:0] qt;
  logic wr_ctl;
  logic rd_done;
  logic live;
  logic rise;
  logic fall;
  assign wr_ctl = avs_write && avs_address == paccum_pkg::ADDR_CONTROL;
  assign rd_done = avs_read && !avs_waitrequest;
  assign live = ctl_sh[6] && !(ctl_sh[5] && !timer_enable);
  // Window spans both sync latencies the note allows
  assign rise = |(~hist[5:2] & hist[4:1]);
  assign fall = |(hist[5:2] & ~hist[4:1]);
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctl_sh <= 8'h00;
      hist <= 7'h00;
      stl <= 4'h0;
      qt <= 4'h0;
    end
    else
    begin
      hist <= {hist[5:0], accum_input_pin};
      if (wr_ctl && !avs_waitrequest)
        ctl_sh <= avs_writedata[7:0];
      stl <= (wr_ctl && !avs_waitrequest) ? 4'h0 : (stl == 4'hf ? stl : stl + 4'h1);
      qt <= live ? 4'h0 : (qt == 4'hf ? qt : qt + 4'h1);
    end
  end
  // ------------------------------
  // Properties
  // ------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_wait_first;
    (avs_read || avs_write) && !$past(avs_read || avs_write) |-> avs_waitrequest;
  endproperty
  a_wait_first: assert property (p_wait_first) else $error("no wait cycle");
  property p_wait_end;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_end: assert property (p_wait_end) else $error("request not answered");
  property p_ctl_back;
    rd_done && avs_address == paccum_pkg::ADDR_CONTROL
      |-> avs_readdata == {24'h000000, ctl_sh & paccum_pkg::CTL_WRITE_MASK};
  endproperty
  a_ctl_back: assert property (p_ctl_back) else $error("control readback");
  property p_flg_rsv;
    rd_done && avs_address == paccum_pkg::ADDR_FLAGS |-> avs_readdata[31:2] == 30'h0;
  endproperty
  a_flg_rsv: assert property (p_flg_rsv) else $error("flag reserved bits");
  property p_quiet;
    qt >= 4'h8 |-> !accum_clock;
  endproperty
  a_quiet: assert property (p_quiet) else $error("count while stopped");
  property p_event_edge;
    stl >= 4'h8 && ctl_sh[6] && !ctl_sh[5] && accum_clock |-> (ctl_sh[4] ? rise : fall);
  endproperty
  a_event_edge: assert property (p_event_edge) else $error("wrong edge counted");
  property p_gate_level;
    stl >= 4'h8 && ctl_sh[6] && ctl_sh[5] && accum_clock
      |-> (ctl_sh[4] ? !(&hist[6:1]) : |hist[6:1]);
  endproperty
  a_gate_level: assert property (p_gate_level) else $error("ungated tick");
  property p_irq_en;
    accum_irq |-> |(ctl_sh[1:0] | (wr_ctl ? avs_writedata[1:0] : 2'h0));
  endproperty
  a_irq_en: assert property (p_irq_en) else $error("irq without enable");
endmodule : paccum_ctrl_checker

bind paccum_ctrl paccum_ctrl_checker #(.PRESCALE_DIVIDE(PRESCALE_DIVIDE)) u_chk (
  .clk(clk),
  .reset_n(reset_n),
  .avs_address(avs_address),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .accum_input_pin(accum_input_pin),
  .timer_enable(timer_enable),
  .accum_clock(accum_clock),
  .accum_irq(accum_irq)
);

// ==== paccum_pulse_src.sv ====
// External pulse and gate source on the accumulator input
module paccum_pulse_src (
  input wire logic clk,
  output logic accum_input_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  initial accum_input_pin = 1'b0;
  // Held 4 cycles so the synchroniser never drops a level
  task automatic level(input logic v);
    @(posedge clk);
    accum_input_pin <= v;
    repeat (4) @(posedge clk);
  endtask : level
  task automatic pulses(input int k);
    for (int i = 0; i < k; i++)
    begin
      level(1'b1);
      level(1'b0);
      repeat ($urandom_range(3, 0)) @(posedge clk);
    end
  endtask : pulses
endmodule : paccum_pulse_src

// ==== testbench.sv ====
// Self-checking testbench for the pulse accumulator control block
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_mismatch++; \
  $display("wrong value at %0t: got %h want %h", $time, a, b); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [1:0] avs_address = 2'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic accum_input_pin;
  logic timer_enable;
  logic accum_clock;
  logic counter_tick;
  logic accum_irq;
  logic [63:0] exp_q[$];
  logic [63:0] cur;
  int n_mismatch = 0;
  int n_checks = 0;
  int n_tick = 0;
  int n;
  int e;
  always #50 clk = ~clk;
  paccum_ctrl #(.PRESCALE_DIVIDE(1)) u_dut (.clk(clk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .accum_input_pin(accum_input_pin),
    .timer_enable(timer_enable), .accum_clock(accum_clock),
    .counter_tick(counter_tick), .accum_irq(accum_irq));
  paccum_pulse_src u_src (.clk(clk), .accum_input_pin(accum_input_pin));
  // ------------------------------
  // Bus master and result monitor
  // ------------------------------
  task automatic wr(input logic [1:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, input logic [31:0] x, input logic [31:0] m);
    exp_q.push_back({m, x});
    @(posedge clk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
  endtask : rd
  always @(posedge clk)
  begin
    if (counter_tick === 1'b1)
      n_tick++;
    if (avs_read && avs_waitrequest === 1'b0)
    begin
      cur = exp_q.pop_front();
      `CHK(avs_readdata & cur[63:32], cur[31:0])
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    end_of_test();
  end
  // ------------------------------
  // Scenarios
  // ------------------------------
  initial
  begin
    void'($urandom(7399));
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    for (int a = 0; a < 4; a++)
      rd(a[1:0], 32'h0, 32'hffffffff);
    wr(2'h0, 32'hff);
    rd(2'h0, 32'h7f, 32'hffffffff);
    for (e = 0; e < 2; e++)
    begin
      n = $urandom_range(8, 1);
      u_src.level(1'b0);
      repeat (8) @(posedge clk);
      wr(2'h0, 32'h40 | (e << 4));
      wr(2'h2, 32'h0);
      wr(2'h1, 32'h3);
      u_src.pulses(n);
      u_src.level(1'b1);
      repeat (8) @(posedge clk);
      rd(2'h2, n + e, 32'hffffffff);
      rd(2'h1, 32'h1, 32'hffffffff);
    end
    wr(2'h1, 32'h0);
    rd(2'h1, 32'h1, 32'hffffffff);
    wr(2'h0, 32'h51);
    @(posedge clk);
    `CHK(accum_irq, 1'b1)
    wr(2'h1, 32'h1);
    rd(2'h1, 32'h0, 32'hffffffff);
    `CHK(accum_irq, 1'b0)
    wr(2'h0, 32'h52);
    wr(2'h2, 32'hffff);
    u_src.level(1'b0);
    u_src.level(1'b1);
    repeat (8) @(posedge clk);
    rd(2'h2, 32'h0, 32'hffffffff);
    rd(2'h1, 32'h3, 32'hffffffff);
    `CHK(accum_irq, 1'b1)
    wr(2'h1, 32'h2);
    rd(2'h1, 32'h1, 32'hffffffff);
    `CHK(accum_irq, 1'b0)
    wr(2'h3, 32'h2);
    rd(2'h2, 32'h0, 32'hffffffff);
    rd(2'h1, 32'h0, 32'hffffffff);
    wr(2'h3, 32'h0);
    // Setup order: idle level, registers, gate level, timer last
    for (e = 1; e >= 0; e--)
    begin
      u_src.level(e[0]);
      wr(2'h0, 32'h60 | (e << 4));
      wr(2'h2, 32'h0);
      wr(2'h1, 32'h3);
      u_src.level(e == 0);
      repeat (200) @(posedge clk);
      rd(2'h2, 32'h0, 32'hffffffff);
      wr(2'h3, 32'h1);
      @(posedge clk);
      `CHK(timer_enable, 1'b1)
      repeat (352) @(posedge clk);
      u_src.level(e[0]);
      wr(2'h3, 32'h0);
      repeat (8) @(posedge clk);
      rd(2'h2, 32'h4, 32'hfffffffc);
      rd(2'h1, 32'h1, 32'hffffffff);
    end
    wr(2'h0, 32'h04);
    wr(2'h3, 32'h1);
    n = n_tick;
    repeat (400) @(posedge clk);
    `CHK(n_tick - n >= 399 && n_tick - n <= 401, 1'b1)
    wr(2'h3, 32'h0);
    for (e = 1; e < 4; e++)
    begin
      wr(2'h0, 32'h50 | (e << 2));
      wr(2'h2, e == 2 ? 32'hfe : (e == 3 ? 32'hfffe : 32'h0));
      n = n_tick;
      u_src.pulses(3);
      repeat (8) @(posedge clk);
      `CHK(n_tick - n, (e == 1) ? 3 : 1)
    end
    // Upper byte lane alone leaves the low count byte untouched
    avs_byteenable <= 4'h2;
    wr(2'h2, 32'h1234);
    avs_byteenable <= 4'hf;
    rd(2'h2, 32'h1201, 32'hffffffff);
    end_of_test();
  end
endmodule : testbench
